// *** design/minmax_pkg.sv ***
// package: constants for the running min/max tracker
// assumes: single clock domain, avalon-mm register access
package minmax_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MIN = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'hC;
  // ctrl fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // irq status/enable/clear layout: status from bit 0, enable from bit 8, clear from bit 16 of the irq word
  localparam int IRQ_NEWMIN_BIT = 0;
  localparam int IRQ_NEWMAX_BIT = 1;
  localparam int IRQ_EN_SHIFT = 8;
  localparam int IRQ_CLR_SHIFT = 16;
  localparam logic [DATA_W-1:0] EXTREME_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// *** design/minmax_tracker.sv ***
// minmax_tracker: running signed minimum and maximum of a 32-bit sample
// assumes: controller logic on clk_sys drives enable, mode, trigger, clear, sample
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Function
// - evaluate only while enable is high
// - store lower sample as min, higher as max
// - both extremes start at zero
// - clear forces both extremes to zero
// - mode 0: evaluate every cycle, ignore trigger
// - mode 1: evaluate on trigger rising edge
// - pulse event one cycle on new extreme
// - min output shows smallest captured sample
// - max output shows largest captured sample
// - signed 32-bit comparison over full range
module minmax_tracker
  import minmax_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable_in,
  input wire logic trigger_mode_select,
  input wire logic trigger_in,
  input wire logic clear_in,
  input wire logic signed [DATA_W-1:0] sample_in,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic signed [DATA_W-1:0] min_out,
  output logic signed [DATA_W-1:0] max_out,
  output logic new_extreme_pulse,
  output logic irq
);
  logic signed [DATA_W-1:0] min_ff;
  logic signed [DATA_W-1:0] max_ff;
  logic trig_prev_ff;
  logic pulse_ff;
  logic [2:0] ctrl_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic ack_ff;
  logic wait_ff;
  logic en_eff;
  logic mode_eff;
  logic clr_eff;
  logic eval;
  logic lower;
  logic higher;
  logic new_min;
  logic new_max;
  logic bus_req;
  logic wr_ctrl;
  logic wr_irq;
  logic [1:0] irq_clr;

  // pins and software control combine
  assign en_eff = enable_in | ctrl_ff[CTRL_EN_BIT];
  assign mode_eff = trigger_mode_select | ctrl_ff[CTRL_MODE_BIT];
  assign clr_eff = clear_in | ctrl_ff[CTRL_CLR_BIT];

  assign eval = en_eff & (~mode_eff | (trigger_in & ~trig_prev_ff));

  assign lower = sample_in < min_ff;
  assign higher = sample_in > max_ff;

  assign new_min = eval & ~clr_eff & lower;
  assign new_max = eval & ~clr_eff & higher;

  // trigger history for edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trigger_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      min_ff <= EXTREME_RESET;
      max_ff <= EXTREME_RESET;
    end else if (clr_eff) begin
      min_ff <= EXTREME_RESET;
      max_ff <= EXTREME_RESET;
    end else begin
      if (new_min) begin
        min_ff <= sample_in;
      end
      if (new_max) begin
        max_ff <= sample_in;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= new_min | new_max;
    end
  end

  // avalon slave: one wait cycle, writes land on the accepting edge
  assign bus_req = (avs_read | avs_write) & ~ack_ff;
  assign wr_ctrl = ack_ff & avs_write & (avs_address == ADDR_CTRL) & avs_byteenable[0];
  assign wr_irq = ack_ff & avs_write & (avs_address == ADDR_IRQ_STAT);
  assign irq_clr = (wr_irq & avs_byteenable[2]) ?
                   avs_writedata[IRQ_CLR_SHIFT +: 2] : 2'b00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // waitrequest kept in its own flop, high while idle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~bus_req;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_en_ff <= 2'b00;
    end else if (wr_irq && avs_byteenable[1]) begin
      irq_en_ff <= avs_writedata[IRQ_EN_SHIFT +: 2];
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= 2'b00;
    end else begin
      irq_stat_ff[IRQ_NEWMIN_BIT] <= new_min | (irq_stat_ff[IRQ_NEWMIN_BIT] & ~irq_clr[0]);
      irq_stat_ff[IRQ_NEWMAX_BIT] <= new_max | (irq_stat_ff[IRQ_NEWMAX_BIT] & ~irq_clr[1]);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= UNMAPPED_READ;
    end else if (bus_req && avs_read) begin
      case (avs_address)
        ADDR_CTRL: rdata_ff <= {29'h0, ctrl_ff};
        ADDR_MIN: rdata_ff <= min_ff;
        ADDR_MAX: rdata_ff <= max_ff;
        ADDR_IRQ_STAT: rdata_ff <= {22'h0, irq_en_ff, 6'h0, irq_stat_ff};
        default: rdata_ff <= UNMAPPED_READ;
      endcase
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign min_out = min_ff;
  assign max_out = max_ff;
  assign new_extreme_pulse = pulse_ff;
  assign irq = irq_ff;
endmodule // minmax_tracker
`default_nettype wire

// *** test/minmax_asserts.sv ***
// checker: pin-level behaviour of the min/max tracker
// assumes: bound into minmax_tracker, ctrl register at reset
`timescale 1ns/10ps
`default_nettype none
module minmax_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable_in,
  input wire logic trigger_mode_select,
  input wire logic trigger_in,
  input wire logic clear_in,
  input wire logic signed [31:0] sample_in,
  input wire logic signed [31:0] min_out,
  input wire logic signed [31:0] max_out,
  input wire logic new_extreme_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_eval;
    enable_in && !clear_in && (!trigger_mode_select || $rose(trigger_in));
  endsequence
  sequence s_hold;
    $stable(min_out) && $stable(max_out) && !new_extreme_pulse;
  endsequence
  a_clear_zero: assert property (clear_in |=> !{min_out, max_out}) else $error("c");
  a_clear_quiet: assert property (clear_in |=> !new_extreme_pulse) else $error("q");
  a_idle_hold: assert property (!enable_in && !clear_in |=> s_hold) else $error("i");
  a_edge_gate: assert property (
    trigger_mode_select && !clear_in && !$rose(trigger_in) |=> s_hold) else $error("g");
  a_new_min: assert property (
    s_eval ##0 sample_in < min_out |=> min_out == $past(sample_in) && new_extreme_pulse)
    else $error("n");
  a_new_max: assert property (
    s_eval ##0 sample_in > max_out |=> max_out == $past(sample_in) && new_extreme_pulse)
    else $error("x");
  a_no_extreme: assert property (
    s_eval ##0 sample_in >= min_out && sample_in <= max_out |=> s_hold) else $error("e");
  a_zero_span: assert property (min_out <= 0 && max_out >= 0) else $error("z");
endmodule // minmax_asserts
bind minmax_tracker minmax_asserts i_minmax_asserts (.*);
`default_nettype wire

// *** test/trig_src.sv ***
// model: controller-side trigger source
// assumes: bench holds fire while triggers are wanted
`timescale 1ns/10ps
`default_nettype none
module trig_src (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic fire,
  output logic trigger_in
);
  logic last_ff;
  assign trigger_in = fire && !last_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) last_ff <= 1'h0;
    else last_ff <= trigger_in;
  end
endmodule // trig_src
`default_nettype wire

// *** test/tb_top.sv ***
// bench: pin steps and avalon-mm calls against tracked extremes
// assumes: package, design, checker and trig_src compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import minmax_pkg::*;
  logic clk_sys, rstn, enable_in, trigger_mode_select, fire, trigger_in, clear_in, ev;
  logic avs_read, avs_write, avs_waitrequest, new_extreme_pulse, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic signed [31:0] sample_in, min_out, max_out, lo, hi;
  int num_errors, num_checks;
  trig_src i_trig_src (.*);
  minmax_tracker i_minmax_tracker (.*);
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #100000 num_errors++;
    results;
  end
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  task results;
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do @(posedge clk_sys); while (avs_waitrequest);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge clk_sys);
  endtask
  task step(input logic [3:0] f, input logic signed [31:0] s);
    {enable_in, trigger_mode_select, fire, clear_in} <= f;
    sample_in <= s;
    ev = f[3] && (!f[2] || f[1]) && !f[0] && (s < lo || s > hi);
    if (f[0]) {lo, hi} = 64'h0;
    if (ev && s < lo) lo = s;
    if (ev && s > hi) hi = s;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(min_out, lo);
    chk(max_out, hi);
    chk(32'(new_extreme_pulse), 32'(ev));
    @(posedge clk_sys);
  endtask
  initial begin
    {rstn, enable_in, trigger_mode_select, fire, clear_in, avs_read, avs_write} = 7'h0;
    {avs_address, avs_writedata, sample_in, lo, hi} = 132'h0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    bus(1'h0, ADDR_MIN, 0);
    chk(q, 32'h0000_0000);
    bus(1'h1, ADDR_IRQ_STAT, 32'h0000_0300);
    step(4'h8, -5);
    step(4'h8, 7);
    step(4'hA, 3);
    step(4'h8, 32'h8000_0000);
    step(4'h8, 32'h7FFF_FFFF);
    step(4'h0, -100);
    bus(1'h0, ADDR_MAX, 0);
    chk(q, hi);
    chk(32'(irq), 32'h1);
    bus(1'h1, ADDR_IRQ_STAT, 0);
    bus(1'h0, 4'h2, 0);
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'h1, ADDR_IRQ_STAT, 32'h0003_0300);
    bus(1'h0, 4'h2, 0);
    chk(32'(irq), 32'h0);
    step(4'h9, -100);
    step(4'hC, -9);
    step(4'hE, -9);
    step(4'hE, -20);
    bus(1'h1, ADDR_CTRL, 32'h0000_0002);
    bus(1'h0, ADDR_CTRL, 0);
    chk(q, 32'h0000_0002);
    bus(1'h1, ADDR_CTRL, 0);
    bus(1'h0, ADDR_CTRL, 0);
    chk(q, 32'h0000_0000);
    results;
  end
endmodule // tb_top
`default_nettype wire
